// ---- logic/tss_defs.vh ----
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// register byte addresses
`define TSS_CONFIG_ADDR 32'h40005C00
`define TSS_STATUS_ADDR 32'h40005C04

// status field positions
`define TSS_SEQ_DONE_BIT 15
`define TSS_LAST_PAIR_BIT 14
`define TSS_T2_DONE_BIT 13
`define TSS_T2_BEGUN_BIT 12
`define TSS_T1_DONE_BIT 11
`define TSS_T1_BEGUN_BIT 10
`define TSS_FLAG_LSB 10
`define TSS_FLAG_MSB 15
`define TSS_ACTIVE_BIT 8
`define TSS_LEFT_MSB 7

// config field positions
`define TSS_ENABLE_BIT 8
`define TSS_REPEAT_MSB 7

// values
`define TSS_STATUS_RESET 16'h0000
`define TSS_REPEAT_RESET 8'h00
`define TSS_PULSE_COUNT 8'h00
`define TSS_LAST_COUNT 8'h01
`define TSS_ENDLESS_COUNT 8'hFF
`define TSS_RESP_OKAY 2'b00
`define TSS_RESP_SLVERR 2'b10

`endif

// ---- logic/tss_event_flag.v ----
`timescale 1ns/10ps
module tss_event_flag
(
  // clock and reset
  input wire clk,
  input wire rst,
  // set by hardware, cleared by software
  input wire set,
  input wire clr,
  output reg flag
);

  always @(posedge clk)
  begin
    if (rst)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end

endmodule // tss_event_flag

// ---- logic/tss_axil_wr.v ----
`timescale 1ns/10ps
module tss_axil_wr
(
  // clock and reset
  input wire clk,
  input wire rst,
  // write address channel
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  // write data channel
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // write response channel
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // towards the register file
  input wire [1:0] resp_in,
  output reg [31:0] addr,
  output reg [31:0] data,
  output reg [3:0] strb,
  output wire go
);

  reg aw_held;
  reg w_held;

  // address and data may arrive in either order; each is parked
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign go = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      addr <= 32'h00000000;
      data <= 32'h00000000;
      strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_held)
      begin
        aw_held <= 1'b1;
        addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held)
      begin
        w_held <= 1'b1;
        data <= s_axi_wdata;
        strb <= s_axi_wstrb;
      end
      if (go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= resp_in;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

endmodule // tss_axil_wr

// ---- logic/tss_sounder.v ----
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "tss_defs.vh"
module tss_sounder
(
  // clock and reset
  input wire clk,
  input wire rst,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // axi4-lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // tone engine, same clock
  input wire first_tone_expired,
  input wire second_tone_expired,
  output wire first_tone_on,
  output wire second_tone_on
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FIRST = 3'b010;
  localparam [2:0] ST_SECOND = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg seq_mode;
  reg next_seq_mode;
  reg [7:0] repeat_count;
  reg [7:0] next_repeat_count;
  reg [7:0] iterations_left;
  reg [7:0] next_iterations_left;

  reg ev_seq_done;
  reg ev_last_pair;
  reg ev_t2_done;
  reg ev_t2_begun;
  reg ev_t1_done;
  reg ev_t1_begun;

  wire [31:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_go;
  reg [1:0] wr_resp;
  reg cfg_sel;
  reg status_sel;
  wire cfg_hit;
  wire status_hit;
  wire enable_write;
  wire enable_value;
  wire endless;
  wire active;
  reg [7:0] shown_left;
  wire [5:0] flag_set;
  reg [5:0] flag_clr;
  wire [5:0] flags;
  wire [15:0] status_word;
  reg [31:0] rd_word;
  reg [1:0] rd_resp;

  // write channel front end
  tss_axil_wr u_wr
  (
    .clk(clk),
    .rst(rst),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .resp_in(wr_resp),
    .addr(wr_addr),
    .data(wr_data),
    .strb(wr_strb),
    .go(wr_go)
  );

  // write address decode; unmapped writes change nothing
  always @*
  begin
    cfg_sel = 1'b0;
    status_sel = 1'b0;
    wr_resp = `TSS_RESP_SLVERR;
    if (wr_addr == `TSS_CONFIG_ADDR)
    begin
      cfg_sel = 1'b1;
      wr_resp = `TSS_RESP_OKAY;
    end
    else if (wr_addr == `TSS_STATUS_ADDR)
    begin
      status_sel = 1'b1;
      wr_resp = `TSS_RESP_OKAY;
    end
  end

  assign cfg_hit = wr_go & cfg_sel;
  assign status_hit = wr_go & status_sel;

  // the enable bit sits in byte lane 1 and is never stored
  assign enable_write = cfg_hit & wr_strb[1];
  assign enable_value = wr_data[`TSS_ENABLE_BIT];

  // repeat count takes effect at once, also mid-sequence
  always @*
  begin
    if (cfg_hit & wr_strb[0])
      next_repeat_count = wr_data[`TSS_REPEAT_MSB:0];
    else
      next_repeat_count = repeat_count;
  end

  assign endless = (repeat_count == `TSS_ENDLESS_COUNT);
  assign active = (state != ST_IDLE);
  assign first_tone_on = (state == ST_FIRST);
  assign second_tone_on = (state == ST_SECOND);

  // sequencer: software disable wins over a tone expiring the same cycle
  always @*
  begin
    next_state = state;
    next_seq_mode = seq_mode;
    next_iterations_left = iterations_left;
    ev_seq_done = 1'b0;
    ev_last_pair = 1'b0;
    ev_t2_done = 1'b0;
    ev_t2_begun = 1'b0;
    ev_t1_done = 1'b0;
    ev_t1_begun = 1'b0;
    case (state)
      ST_IDLE:
      begin
        // while idle the field mirrors the programmed count
        next_iterations_left = next_repeat_count;
        if (enable_write & enable_value)
        begin
          next_state = ST_FIRST;
          ev_t1_begun = 1'b1;
          next_seq_mode = (next_repeat_count != `TSS_PULSE_COUNT);
          if (next_repeat_count == `TSS_LAST_COUNT)
            ev_last_pair = 1'b1;
        end
      end
      ST_FIRST:
      begin
        if (enable_write & ~enable_value)
        begin
          next_state = ST_IDLE;
          ev_t1_done = 1'b1;
          ev_seq_done = seq_mode;
          next_iterations_left = next_repeat_count;
        end
        else if (first_tone_expired)
        begin
          ev_t1_done = 1'b1;
          if (seq_mode)
          begin
            next_state = ST_SECOND;
            ev_t2_begun = 1'b1;
          end
          else
          begin
            next_state = ST_IDLE;
            next_iterations_left = next_repeat_count;
          end
        end
      end
      ST_SECOND:
      begin
        if (enable_write & ~enable_value)
        begin
          next_state = ST_IDLE;
          ev_t2_done = 1'b1;
          ev_seq_done = 1'b1;
          next_iterations_left = next_repeat_count;
        end
        else if (second_tone_expired)
        begin
          ev_t2_done = 1'b1;
          if (endless)
          begin
            next_state = ST_FIRST;
            ev_t1_begun = 1'b1;
          end
          else if (iterations_left <= `TSS_LAST_COUNT)
          begin
            next_state = ST_IDLE;
            ev_seq_done = 1'b1;
            next_iterations_left = next_repeat_count;
          end
          else
          begin
            next_state = ST_FIRST;
            ev_t1_begun = 1'b1;
            next_iterations_left = iterations_left - `TSS_LAST_COUNT;
            if (iterations_left == 8'h02)
              ev_last_pair = 1'b1;
          end
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_seq_mode = 1'b0;
        next_iterations_left = next_repeat_count;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      seq_mode <= 1'b0;
      repeat_count <= `TSS_REPEAT_RESET;
      iterations_left <= `TSS_REPEAT_RESET;
    end
    else
    begin
      state <= next_state;
      seq_mode <= next_seq_mode;
      repeat_count <= next_repeat_count;
      iterations_left <= next_iterations_left;
    end
  end

  // an endless run always shows the endless count
  always @*
  begin
    if (active & seq_mode & endless)
      shown_left = `TSS_ENDLESS_COUNT;
    else
      shown_left = iterations_left;
  end

  // event flags, ordered from bit 10 upward
  assign flag_set = {ev_seq_done, ev_last_pair, ev_t2_done,
                     ev_t2_begun, ev_t1_done, ev_t1_begun};
  always @*
  begin
    if (status_hit & wr_strb[1])
      flag_clr = wr_data[`TSS_FLAG_MSB:`TSS_FLAG_LSB];
    else
      flag_clr = 6'h00;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_flag
      tss_event_flag u_flag
      (
        .clk(clk),
        .rst(rst),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // reserved bit 9 reads as zero
  assign status_word = {flags, 1'b0, active, shown_left};

  // read decode, captured on the edge that takes the address
  always @*
  begin
    if (s_axi_araddr == `TSS_STATUS_ADDR)
    begin
      rd_word = {16'h0000, status_word};
      rd_resp = `TSS_RESP_OKAY;
    end
    else if (s_axi_araddr == `TSS_CONFIG_ADDR)
    begin
      // enable always reads back zero
      rd_word = {24'h000000, repeat_count};
      rd_resp = `TSS_RESP_OKAY;
    end
    else
    begin
      rd_word = 32'h00000000;
      rd_resp = `TSS_RESP_SLVERR;
    end
  end

  // read channel: one outstanding read, answered the cycle after ar
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TSS_RESP_OKAY;
    end
    else if (s_axi_arvalid & ~s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // tss_sounder

// ---- verification/tss_sounder_properties.sv ----
`timescale 1ns/10ps
`include "tss_defs.vh"
module tss_sounder_properties
(
  // clock and reset
  input wire clk,
  input wire rst,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // tone engine
  input wire first_tone_expired,
  input wire second_tone_expired,
  input wire first_tone_on,
  input wire second_tone_on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_excl; !(first_tone_on && second_tone_on); endproperty
  a_excl: assert property (p_excl)
    else $error("both tones on");
  property p_t2_on;
    $rose(second_tone_on) |-> $past(first_tone_on && first_tone_expired);
  endproperty
  a_t2_on: assert property (p_t2_on)
    else $error("second tone without first");
  // the effect of a config write lands on the edge that raises bvalid
  property p_t1_on;
    $rose(first_tone_on) |-> $rose(s_axi_bvalid) ||
      $past(second_tone_on && second_tone_expired);
  endproperty
  a_t1_on: assert property (p_t1_on)
    else $error("first tone started without cause");
  property p_t1_off;
    $fell(first_tone_on) |-> $past(first_tone_expired) || $rose(s_axi_bvalid);
  endproperty
  a_t1_off: assert property (p_t1_off)
    else $error("first tone stopped without cause");
  property p_t2_off;
    $fell(second_tone_on) |-> $past(second_tone_expired) ||
      $rose(s_axi_bvalid);
  endproperty
  a_t2_off: assert property (p_t2_off)
    else $error("second tone stopped without cause");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write response late");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd)
    else $error("read response late");
  property p_stat;
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == `TSS_STATUS_ADDR |->
      s_axi_rdata[8] == $past(first_tone_on || second_tone_on) &&
      s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[9];
  endproperty
  a_stat: assert property (p_stat)
    else $error("activity bit wrong");
endmodule // tss_sounder_properties
bind tss_sounder tss_sounder_properties u_props
(
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .first_tone_expired(first_tone_expired),
  .second_tone_expired(second_tone_expired),
  .first_tone_on(first_tone_on), .second_tone_on(second_tone_on)
);

// ---- verification/tb_tss_sounder.sv ----
`timescale 1ns/10ps
`include "tss_defs.vh"
module tb_tss_sounder;
  localparam logic [31:0] ca = `TSS_CONFIG_ADDR;
  localparam logic [31:0] sa = `TSS_STATUS_ADDR;
  localparam logic [1:0] ok = `TSS_RESP_OKAY;
  localparam logic [1:0] se = `TSS_RESP_SLVERR;
  logic clk = 0;
  logic rst = 1;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ftx = 0, stx = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, seed;
  wire awr, wrd, bv, arr, rv, t1_on, t2_on;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int n_fail = 0, checked = 0;
  logic [5:0] ef;
  logic act;
  logic [7:0] left, rep, n;

  always #20 clk = ~clk;

  tss_sounder dut
  (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .first_tone_expired(ftx),
    .second_tone_expired(stx), .first_tone_on(t1_on),
    .second_tone_on(t2_on)
  );

  function automatic logic [31:0] st();
    return {16'h0000, ef, 1'b0, act, left};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (awv && awr)
        ad = 1;
      if (wv && wrd)
        dd = 1;
      if (ad)
        awv <= 0;
      if (dd)
        wv <= 0;
    end
    bre <= 1;
    do @(posedge clk); while (bv !== 1'b1);
    bre <= 0;
    chk(bresp, er);
  endtask

  task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
    arv <= 1;
    ara <= a;
    rre <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge clk); while (rv !== 1'b1);
    rre <= 0;
    chk(rdata, exp);
    chk(rresp, er);
  endtask

  task automatic go(input logic [7:0] c);
    rep = c;
    wr(ca, {23'h0, 1'b1, c}, ok);
    ef |= (c == 1) ? 6'h11 : 6'h01;
    act = 1;
    left = c;
    rd(sa, st(), ok);
    chk(t1_on, 1'b1);
  endtask

  // one expiry pulse from the tone engine, then the model follows it
  task automatic step(input logic sec);
    if (sec)
      stx <= 1;
    else
      ftx <= 1;
    @(posedge clk);
    stx <= 0;
    ftx <= 0;
    if (!sec)
      ef |= (rep == 0) ? 6'h02 : 6'h06;
    else
      ef |= 6'h08;
    if (!sec && rep == 0)
      act = 0;
    if (sec && rep == 8'hFF)
      ef |= 6'h01;
    else if (sec && left <= 1)
    begin
      ef |= 6'h20;
      act = 0;
      left = rep;
    end
    else if (sec)
    begin
      left = left - 1;
      ef |= (left == 1) ? 6'h11 : 6'h01;
    end
    rd(sa, st(), ok);
    chk(t1_on, act && sec);
    chk(t2_on, act && !sec);
  endtask

  task automatic clr();
    wr(sa, 32'hFC00 | ($urandom & 32'h3FF), ok);
    ef = 0;
    rd(sa, st(), ok);
  endtask

  initial
  begin
    seed = $urandom(88);
    ef = 0;
    act = 0;
    left = 0;
    rep = 0;
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(sa, 32'h0, ok);
    rd(ca, 32'h0, ok);
    wr(32'h40005C10, 32'hFFFF, se);
    rd(32'h40005C10, 32'h0, se);
    go(8'h00);
    wr(sa, 32'h0, ok);
    rd(sa, st(), ok);
    step(0);
    clr();
    for (int k = 0; k < 3; k++)
    begin
      n = (k == 0) ? 8'h01 : 8'h02 + 8'($urandom % 4);
      go(n);
      repeat (n)
      begin
        step(0);
        step(1);
      end
      clr();
    end
    n = 8'($urandom);
    rep = n;
    left = n;
    wr(ca, {24'h0, n}, ok);
    rd(ca, {24'h0, n}, ok);
    rd(sa, st(), ok);
    go(8'hFF);
    step(0);
    step(1);
    step(0);
    wr(ca, 32'h000000FF, ok);
    ef |= 6'h28;
    act = 0;
    rd(sa, st(), ok);
    chk(t2_on, 1'b0);
    clr();
    // a clear landing on the edge of the event must lose to it
    go(8'h00);
    fork
      wr(sa, 32'h0C00, ok);
      begin
        @(posedge clk);
        ftx <= 1;
        @(posedge clk);
        ftx <= 0;
      end
    join
    ef = 6'h02;
    act = 0;
    rd(sa, st(), ok);
    // enable while busy is ignored; disable in the first tone ends the run
    go(8'h03);
    wr(ca, 32'h00000103, ok);
    rd(sa, st(), ok);
    chk(t1_on, 1'b1);
    wr(ca, 32'h00000003, ok);
    ef |= 6'h22;
    act = 0;
    rd(sa, st(), ok);
    chk(t1_on, 1'b0);
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule // tb_tss_sounder
